// ### pkg/kbc_cfg.svh
`ifndef KBC_CFG_SVH
`define KBC_CFG_SVH
`define CFG_ACTIVATE      8'h30
`define CFG_IRQ_PRI       8'h70
`define CFG_IRQ_SEC       8'h72
`define CFG_RST_GATE      8'hF0
`define PORT_DATA         8'h60
`define PORT_STAT         8'h64
`define ST_OBF            0
`define ST_IBF            1
`define ST_GP2            2
`define ST_CMD            3
`define CB_PTR_DIS        5
`define CMD_RD_CB         8'h20
`define CMD_WR_CB         8'h60
`define CMD_PW_TEST       8'hA4
`define CMD_PW_LOAD       8'hA5
`define CMD_PW_LOCK       8'hA6
`define CMD_PTR_DIS       8'hA7
`define CMD_PTR_EN        8'hA8
`define RSP_PW_YES        8'hFA
`define RSP_PW_NO         8'hF1
`define PW_END            8'h00
`define PW_DEPTH          8
`define CB_RESET          8'h00
`define ACT_ENABLE_BIT    0
`define APB_ADDR_SEL      32'h0000_0000
`define APB_ADDR_DATA     32'h0000_0004
`define APB_ADDR_STATUS   32'h0000_0008
`define APB_ADDR_CTRL     32'h0000_000C
`endif

// ### pkg/kbc_pkg.sv
package kbc_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CB   = 5'b00010,
    ST_PW   = 5'b00100,
    ST_LOCK = 5'b01000,
    ST_PASS = 5'b10000
  } kbc_state_e;
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_ACC   = 4'b0100,
    H_DONE  = 4'b1000
  } host_state_e;
endpackage

// ### pkg/kbc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface kbc_if;
  logic       rd;
  logic       wr;
  logic [7:0] addr;
  logic       cfg;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev  (input rd, wr, addr, cfg, wdata, output rdata);
  modport host (output rd, wr, addr, cfg, wdata, input rdata);
endinterface
`default_nettype wire

// ### core/kbc_device.sv
// Behaviour
// - data port read returns output buffer
// - data port write loads data, flag data
// - command port write loads command, flag set
// - status read returns status byte
// - status bit3 follows address line two
// - input full set on write, cleared consumed
// - output full set on load, cleared read
// - host reads data only when full
// - host writes only when input empty
// - data bytes forwarded except command parameters
// - command responses go to output buffer
// - command 20h returns command byte
// - command 60h loads next data byte
// - A4h answers FAh stored, F1h none
// - A5h stores characters until 00h
// - A6h locks until password entered, only if a password is stored
// - A7h sets bit5, holds pointer clock
// - A8h clears bit5, releases pointer clock
// - keyboard interrupt when data ready
// - unusable until activated; config registers
// - pointer interrupt separate line
`timescale 1ns/1ps
`default_nettype none
`include "kbc_cfg.svh"
module kbc_device (
  input  wire logic           i_clk,        // system clock
  input  wire logic           i_rstn,       // sync reset, low
  kbc_if.dev                  bus,          // host port
  input  wire logic           i_kbd_valid,  // received keyboard byte
  input  wire kbc_pkg::byte_t i_kbd_data,   // keyboard byte
  input  wire logic           i_ptr_valid,  // received pointer byte
  input  wire kbc_pkg::byte_t i_ptr_data,   // pointer byte
  output logic                o_kbd_valid,  // byte to keyboard
  output kbc_pkg::byte_t      o_kbd_data,   // byte to keyboard data
  output logic                o_ptr_clk_oe, // low while pointer clock pulled low
  output logic                o_kbd_irq,    // keyboard interrupt line
  output logic                o_ptr_irq,    // pointer interrupt line
  output kbc_pkg::byte_t      o_irq_pri,    // primary interrupt select
  output kbc_pkg::byte_t      o_irq_sec,    // secondary interrupt select
  output kbc_pkg::byte_t      o_rst_gate    // reset and high_address_gate select
);
  import kbc_pkg::*;
  kbc_state_e st_r;
  byte_t      act_r;
  byte_t      ibuf_r;
  byte_t      obuf_r;
  byte_t      cb_r;
  logic       obf_r;
  logic       ibf_r;
  logic       cmd_r;
  logic       ptr_src_r;
  logic [3:0] gp_r;
  byte_t      pw_r [`PW_DEPTH];
  logic [3:0] pw_len_r;
  logic [3:0] pw_idx_r;
  logic       pw_ok_r;
  logic       active;
  logic       hwr;
  logic       rd_data;
  logic       consume;
  logic       rsp_v;
  byte_t      rsp_d;

  assign active  = act_r[`ACT_ENABLE_BIT];
  assign hwr     = bus.wr && !bus.cfg && active && (bus.addr == `PORT_DATA ||
                   bus.addr == `PORT_STAT);
  assign rd_data = bus.rd && !bus.cfg && active && bus.addr == `PORT_DATA;
  assign consume = ibf_r;

  always_comb begin
    if (bus.cfg) begin
      unique case (bus.addr)
        `CFG_ACTIVATE: bus.rdata = act_r;
        `CFG_IRQ_PRI:  bus.rdata = o_irq_pri;
        `CFG_IRQ_SEC:  bus.rdata = o_irq_sec;
        `CFG_RST_GATE: bus.rdata = o_rst_gate;
        default:       bus.rdata = 8'h00;
      endcase
    end else if (!active) begin
      bus.rdata = 8'h00;
    end else if (bus.addr == `PORT_DATA) begin
      bus.rdata = obuf_r;
    end else if (bus.addr == `PORT_STAT) begin
      bus.rdata = {gp_r, cmd_r, 1'b0, ibf_r, obf_r};
    end else begin
      bus.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      act_r      <= 8'h00;
      o_irq_pri  <= 8'h00;
      o_irq_sec  <= 8'h00;
      o_rst_gate <= 8'h00;
    end else if (bus.wr && bus.cfg) begin
      unique case (bus.addr)
        `CFG_ACTIVATE: act_r      <= bus.wdata;
        `CFG_IRQ_PRI:  o_irq_pri  <= bus.wdata;
        `CFG_IRQ_SEC:  o_irq_sec  <= bus.wdata;
        `CFG_RST_GATE: o_rst_gate <= bus.wdata;
        default: ;
      endcase
    end
  end

  // input buffer capture; set wins because the write branch is tested before consume
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ibf_r  <= 1'b0;
      cmd_r  <= 1'b0;
      ibuf_r <= 8'h00;
    end else if (hwr) begin
      ibuf_r <= bus.wdata;
      ibf_r  <= 1'b1;
      cmd_r  <= bus.addr[2];
    end else if (consume) begin
      ibf_r  <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      gp_r <= 4'h0;
    end else begin
      gp_r <= {st_r == ST_LOCK, st_r == ST_PW, 2'b00};
    end
  end

  // command decode and parameter handling
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_r        <= ST_IDLE;
      cb_r        <= `CB_RESET;
      pw_len_r    <= 4'd0;
      pw_idx_r    <= 4'd0;
      pw_ok_r     <= 1'b1;
      o_kbd_valid <= 1'b0;
      o_kbd_data  <= 8'h00;
      rsp_v       <= 1'b0;
      rsp_d       <= 8'h00;
    end else begin
      o_kbd_valid <= 1'b0;
      rsp_v       <= 1'b0;
      if (consume) begin
        unique case (st_r)
          ST_CB: begin
            if (!cmd_r) cb_r <= ibuf_r;
            st_r <= ST_IDLE;
          end
          ST_PW: begin
            if (!cmd_r && ibuf_r == `PW_END) begin
              st_r <= ST_IDLE;
            end else if (!cmd_r) begin
              if (pw_len_r < 4'(`PW_DEPTH)) begin
                pw_r[pw_len_r[2:0]] <= ibuf_r;
                pw_len_r <= pw_len_r + 4'd1;
              end
            end else begin
              st_r <= ST_IDLE;
            end
          end
          ST_LOCK: begin
            // everything is swallowed until the password matches
            if (ibuf_r == `PW_END) begin
              if (pw_ok_r && pw_idx_r == pw_len_r) st_r <= ST_IDLE;
              pw_idx_r <= 4'd0;
              pw_ok_r  <= 1'b1;
            end else begin
              if (pw_idx_r >= pw_len_r || pw_r[pw_idx_r[2:0]] != ibuf_r) pw_ok_r <= 1'b0;
              if (pw_idx_r < 4'(`PW_DEPTH)) pw_idx_r <= pw_idx_r + 4'd1;
            end
          end
          default: begin
            if (!cmd_r) begin
              o_kbd_valid <= 1'b1;
              o_kbd_data  <= ibuf_r;
            end else begin
              unique case (ibuf_r)
                `CMD_RD_CB: begin
                  rsp_v <= 1'b1;
                  rsp_d <= cb_r;
                end
                `CMD_WR_CB: st_r <= ST_CB;
                `CMD_PW_TEST: begin
                  rsp_v <= 1'b1;
                  rsp_d <= (pw_len_r != 4'd0) ? `RSP_PW_YES : `RSP_PW_NO;
                end
                `CMD_PW_LOAD: begin
                  st_r     <= ST_PW;
                  pw_len_r <= 4'd0;
                end
                `CMD_PW_LOCK: begin
                  if (pw_len_r != 4'd0) begin
                    st_r     <= ST_LOCK;
                    pw_idx_r <= 4'd0;
                    pw_ok_r  <= 1'b1;
                  end
                end
                `CMD_PTR_DIS: cb_r[`CB_PTR_DIS] <= 1'b1;
                `CMD_PTR_EN:  cb_r[`CB_PTR_DIS] <= 1'b0;
                default: ;
              endcase
            end
          end
        endcase
      end
    end
  end

  // enable is low while the pointer clock pin is driven low
  assign o_ptr_clk_oe = !cb_r[`CB_PTR_DIS];

  // output buffer: responses first, then keyboard, then pointer
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      obf_r     <= 1'b0;
      obuf_r    <= 8'h00;
      ptr_src_r <= 1'b0;
    end else if (rsp_v) begin
      obf_r     <= 1'b1;
      obuf_r    <= rsp_d;
      ptr_src_r <= 1'b0;
    end else if (!obf_r && i_kbd_valid && st_r != ST_LOCK) begin
      obf_r     <= 1'b1;
      obuf_r    <= i_kbd_data;
      ptr_src_r <= 1'b0;
    end else if (!obf_r && i_ptr_valid && !cb_r[`CB_PTR_DIS] && st_r != ST_LOCK) begin
      obf_r     <= 1'b1;
      obuf_r    <= i_ptr_data;
      ptr_src_r <= 1'b1;
    end else if (rd_data) begin
      obf_r     <= 1'b0;
    end
  end

  assign o_kbd_irq = obf_r && !ptr_src_r;
  assign o_ptr_irq = obf_r && ptr_src_r;
endmodule
`default_nettype wire

// ### core/kbc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "kbc_cfg.svh"
module kbc_host (
  input  wire logic         i_clk,     // system clock
  input  wire logic         i_rstn,    // sync reset, low
  input  wire logic         i_psel,    // apb select
  input  wire logic         i_penable, // apb enable
  input  wire logic         i_pwrite,  // apb direction
  input  wire logic [31:0]  i_paddr,   // apb address
  input  wire logic [31:0]  i_pwdata,  // apb write data
  output logic [31:0]       o_prdata,  // apb read data
  output logic              o_pready,  // apb ready
  output logic              o_pslverr, // apb error
  kbc_if.host               port       // device port
);
  import kbc_pkg::*;
  host_state_e st_r;
  logic [8:0]  sel_r;
  byte_t       data_r;
  logic        wr_r;
  logic        busy_r;
  logic        acc;
  logic        hit;

  assign acc = i_psel && i_penable;
  assign hit = i_paddr == `APB_ADDR_SEL || i_paddr == `APB_ADDR_DATA ||
               i_paddr == `APB_ADDR_STATUS || i_paddr == `APB_ADDR_CTRL;
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !hit;

  always_comb begin
    unique case (i_paddr)
      `APB_ADDR_SEL:    o_prdata = {23'h0, sel_r};
      `APB_ADDR_DATA:   o_prdata = {24'h0, data_r};
      `APB_ADDR_STATUS: o_prdata = {31'h0, busy_r};
      default:          o_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sel_r <= 9'h000;
    end else if (acc && i_pwrite && i_paddr == `APB_ADDR_SEL) begin
      sel_r <= i_pwdata[8:0];
    end
  end

  // ctrl write: bit0 direction (1 write), one device access per start
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_r   <= H_IDLE;
      busy_r <= 1'b0;
      wr_r   <= 1'b0;
      data_r <= 8'h00;
      port.rd    <= 1'b0;
      port.wr    <= 1'b0;
      port.addr  <= 8'h00;
      port.cfg   <= 1'b0;
      port.wdata <= 8'h00;
    end else begin
      port.rd <= 1'b0;
      port.wr <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (acc && i_pwrite && i_paddr == `APB_ADDR_DATA) data_r <= i_pwdata[7:0];
          if (acc && i_pwrite && i_paddr == `APB_ADDR_CTRL) begin
            wr_r   <= i_pwdata[0];
            busy_r <= 1'b1;
            st_r   <= H_SETUP;
          end
        end
        H_SETUP: begin
          port.addr  <= sel_r[7:0];
          port.cfg   <= sel_r[8];
          port.wdata <= data_r;
          port.rd    <= !wr_r;
          port.wr    <= wr_r;
          st_r       <= H_ACC;
        end
        H_ACC: begin
          if (!wr_r) data_r <= port.rdata;
          st_r <= H_DONE;
        end
        H_DONE: begin
          busy_r <= 1'b0;
          st_r   <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### testbench/kbc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "kbc_cfg.svh"
module kbc_asserts (
  input wire logic       i_clk,  // clock
  input wire logic       i_rstn, // sync reset, low
  input wire logic       rd,     // read pulse
  input wire logic       wr,     // write pulse
  input wire logic [7:0] addr,   // port or index
  input wire logic       cfg,    // config space
  input wire logic [7:0] wdata,  // write byte
  input wire logic [7:0] rdata   // read byte
);
  logic       act_r;
  logic       a2_r;
  logic       pend_r;
  logic [7:0] pri_r;
  wire        io = !cfg && act_r;
  // shadow of what the port should report
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      act_r  <= 1'b0;
      a2_r   <= 1'b0;
      pend_r <= 1'b0;
      pri_r  <= 8'h00;
    end else begin
      if (wr && cfg && addr == `CFG_ACTIVATE) act_r <= wdata[`ACT_ENABLE_BIT];
      if (wr && cfg && addr == `CFG_IRQ_PRI) pri_r <= wdata;
      if (wr && io) a2_r <= addr[2];
      if (wr && io) pend_r <= addr == `PORT_STAT && wdata == `CMD_PW_TEST;
      else if (rd && io && addr == `PORT_DATA) pend_r <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  AST_RW_EXCL: assert property (!(rd && wr))
    else $error("read and write strobes together");
  AST_WR_PULSE: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  AST_RD_PULSE: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  AST_IDLE_ZERO: assert property (rd && !cfg && !act_r |-> rdata == 8'h00)
    else $error("inactive port returned data");
  AST_CFG_BACK: assert property (rd && cfg && addr == `CFG_IRQ_PRI |-> rdata == pri_r)
    else $error("config index readback wrong");
  AST_CMD_FLAG: assert property (rd && io && addr == `PORT_STAT |-> rdata[3] == a2_r)
    else $error("command flag does not follow last write");
  AST_IBF_DONE: assert property (rd && io && addr == `PORT_STAT |-> rdata[2:1] == 2'b00)
    else $error("input full or flag two set at status read");
  AST_PW_RSP: assert property (rd && io && addr == `PORT_DATA && pend_r |->
    rdata inside {`RSP_PW_YES, `RSP_PW_NO})
    else $error("password test answer out of set");
endmodule
`default_nettype wire

// ### testbench/keyboard_ctrl_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "kbc_cfg.svh"
module keyboard_ctrl_host_port_tb;
  import kbc_pkg::*;
  logic        i_clk = 0, i_rstn = 0, psel = 0, pen = 0, pwr = 0, kv = 0, pv = 0;
  logic [31:0] paddr = 0, pwd = 0, prd, v;
  logic        prdy, perr, okv, poe, kirq, pirq, e;
  byte_t       kd = 0, pd = 0, okd, pri, sec, rg, r, x, p1, p2;
  byte_t       cv [3], fwd_q [$];
  byte_t       ix [3] = '{8'h70, 8'h72, 8'hF0};
  int          err_total = 0, checks = 0, seed = 97, cyc = 0, cb;
  kbc_if bus_if ();
  kbc_device i_kbc_device (.i_clk(i_clk), .i_rstn(i_rstn), .bus(bus_if), .i_kbd_valid(kv),
    .i_kbd_data(kd), .i_ptr_valid(pv), .i_ptr_data(pd), .o_kbd_valid(okv), .o_kbd_data(okd),
    .o_ptr_clk_oe(poe), .o_kbd_irq(kirq), .o_ptr_irq(pirq), .o_irq_pri(pri),
    .o_irq_sec(sec), .o_rst_gate(rg));
  kbc_host i_kbc_host (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .port(bus_if));
  kbc_asserts i_kbc_asserts (.i_clk(i_clk), .i_rstn(i_rstn), .rd(bus_if.rd), .wr(bus_if.wr),
    .addr(bus_if.addr), .cfg(bus_if.cfg), .wdata(bus_if.wdata), .rdata(bus_if.rdata));
  always #50 i_clk = ~i_clk;
  task end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // forwarded bytes are logged, the timeout cuts a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (okv === 1'b1) fwd_q.push_back(okd);
    if (cyc == 10000) begin
      err_total++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] t);
    checks++;
    if (g !== t) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, g, t);
    end
  endtask
  task apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1;
    paddr <= a;
    pwr <= w;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (prdy !== 1'b1);
    v = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task op(input logic c, input byte_t a, input logic w, input byte_t d);
    apb(`APB_ADDR_SEL, 1, {23'h0, c, a});
    apb(`APB_ADDR_DATA, 1, {24'h0, d});
    apb(`APB_ADDR_CTRL, 1, {31'h0, w});
    v = 1;
    while (v[0] === 1'b1) apb(`APB_ADDR_STATUS, 0, 0);
    apb(`APB_ADDR_DATA, 0, 0);
    r = v[7:0];
  endtask
  task wr(input byte_t a, input byte_t d);
    do op(0, `PORT_STAT, 0, 0); while (r[1] === 1'b1);
    op(0, a, 1, d);
  endtask
  task stat(input byte_t t);
    op(0, `PORT_STAT, 0, 0);
    chk(r & 8'h0F, t);
  endtask
  task rdchk(input byte_t t);
    do op(0, `PORT_STAT, 0, 0); while (r[0] !== 1'b1);
    op(0, `PORT_DATA, 0, 0);
    chk(r, t);
  endtask
  task cbchk;
    wr(`PORT_STAT, `CMD_RD_CB);
    stat(8'h09);
    chk(kirq, 1);
    rdchk(cb[7:0]);
    stat(8'h08);
    chk(poe, !cb[5]);
  endtask
  task pw;
    wr(`PORT_DATA, p1);
    wr(`PORT_DATA, p2);
    wr(`PORT_DATA, `PW_END);
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1;
    stat(8'h00);
    wr(`PORT_DATA, 8'h55);
    chk(fwd_q.size(), 0);
    for (int i = 0; i < 3; i++) begin
      cv[i] = 8'($random(seed));
      op(1, ix[i], 1, cv[i]);
      op(1, ix[i], 0, 0);
      chk(r, cv[i]);
    end
    chk({pri, sec, rg}, {cv[0], cv[1], cv[2]});
    op(1, `CFG_ACTIVATE, 1, 8'h01);
    stat(8'h00);
    x = 8'($random(seed));
    wr(`PORT_DATA, x);
    chk(fwd_q.size(), 1);
    chk(fwd_q.pop_front(), x);
    stat(8'h00);
    x = 8'($random(seed));
    wr(`PORT_STAT, `CMD_WR_CB);
    stat(8'h08);
    wr(`PORT_DATA, x);
    cb = x;
    chk(fwd_q.size(), 0);
    cbchk();
    for (int k = 0; k < 2; k++) begin
      wr(`PORT_STAT, k ? `CMD_PTR_EN : `CMD_PTR_DIS);
      cb[5] = !k;
      cbchk();
    end
    wr(`PORT_STAT, `CMD_PW_TEST);
    rdchk(`RSP_PW_NO);
    p1 = 8'($random(seed)) | 8'h01;
    p2 = 8'($random(seed)) | 8'h01;
    wr(`PORT_STAT, `CMD_PW_LOAD);
    pw();
    chk(fwd_q.size(), 0);
    wr(`PORT_STAT, `CMD_PW_TEST);
    rdchk(`RSP_PW_YES);
    for (int k = 0; k < 2; k++) begin
      x = 8'($random(seed));
      @(posedge i_clk);
      kv <= !k[0];
      pv <= k[0];
      kd <= x;
      pd <= x;
      @(posedge i_clk);
      kv <= 0;
      pv <= 0;
      repeat (3) @(posedge i_clk);
      chk({kirq, pirq}, {!k[0], k[0]});
      stat(8'h09);
      rdchk(x);
      chk({kirq, pirq}, 2'b00);
    end
    wr(`PORT_STAT, `CMD_PW_LOCK);
    wr(`PORT_STAT, `CMD_PW_TEST);
    stat(8'h08);
    // the swallowed test command spoils this first attempt
    pw();
    op(0, `PORT_STAT, 0, 0);
    chk(r[7:6], 2'b10);
    pw();
    wr(`PORT_STAT, `CMD_PW_TEST);
    rdchk(`RSP_PW_YES);
    apb(32'h0000_0010, 0, 0);
    chk(e, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
